// ### rtl/itsio_top.sv
// Purpose: illumination colour sequencing, pattern triggers, interlock and sensor pin functions
// Assumes: single 40 MHz clock, asynchronous active-high reset plus a pin-level power-on reset
// Notes: gpio pin functions are chosen by plain mode ports
`timescale 1ns/10ps
`default_nettype none
module itsio_top
  import itsio_pkg::*;
#(
  parameter int unsigned RELEASE_COUNT = RELEASE_CYC,
  parameter int unsigned SEQ_LEN_W     = 4
)
(
  input  wire logic                 REF_CLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 POWER_ON_RESET_N,
  input  wire logic                 PATTERN_ADVANCE_IN,
  input  wire logic                 COMPARATOR_RESULT_IN,
  input  wire logic [SEQ_LEN_W-1:0] SEQ_LENGTH,
  input  wire logic [2*SEQ_MAX-1:0] SEQ_COLOURS,
  input  wire logic [15:0]          EXPOSE_CYCLES,
  input  wire logic                 GPIO07_INTERLOCK_MODE,
  input  wire logic                 GPIO07_SAMPLE_MODE,
  input  wire logic                 SENSOR_ENABLE,
  input  wire logic                 THERM_ENABLE,
  input  wire logic                 KEYPAD_ENABLE,
  input  wire logic [2:0]           GPIO_KEY_IN,
  input  wire logic                 GPIO07_IN,
  output logic [1:0]                ILLUM_COLOUR_CODE,
  output logic                      ILLUM_DRIVER_ON,
  output logic                      EXPOSURE_ACTIVE_OUT,
  output logic                      SEQUENCE_FIRST_OUT,
  output logic                      COMPARATOR_REF_PWM_OUT,
  output logic [ADC_W-1:0]          ADC_RESULT,
  output logic                      ADC_DONE,
  output logic                      INIT_DONE,
  output logic [2:0]                KEYPAD_STATE,
  output logic [4:0]                SENSOR_PINS_DOUT,
  output logic [4:0]                SENSOR_PINS_OE,
  output logic [2:0]                KEY_PINS_DOUT,
  output logic [2:0]                KEY_PINS_OE,
  output logic                      GPIO07_DOUT,
  output logic                      GPIO07_OE
);

  typedef struct packed {
    logic [1:0]           por_sync;
    logic [1:0]           adv_sync;
    logic [1:0]           ilk_sync;
    logic [1:0]           cmp_sync;
    logic [2:0]           key_sync1;
    logic [2:0]           key_sync2;
    logic                 adv_prev;
    logic                 ilk_prev;
    logic                 ilk_ok;
    logic [22:0]          ilk_cnt;
    logic [7:0]           init_cnt;
    itsio_state_e         state;
    logic [SEQ_LEN_W-1:0] pat_idx;
    logic [15:0]          exp_cnt;
    logic [PWM_W-1:0]     pwm_cnt;
    logic [ADC_W-1:0]     sar_trial;
    logic [ADC_W-1:0]     sar_mask;
    logic [ADC_W-1:0]     adc_result;
    logic                 adc_done;
    logic [1:0]           colour;
    logic                 drv_on;
    logic                 expose_out;
    logic                 first_out;
    logic                 pwm_out;
    logic                 init_done;
    logic [2:0]           keys;
    logic                 adc_run;
  } itsio_st_s;

  itsio_st_s st_reg;
  itsio_st_s st_next;

  // colour code of one sequence slot
  function automatic logic [1:0] slot_colour(input logic [2*SEQ_MAX-1:0] tbl, input logic [SEQ_LEN_W-1:0] idx);
    slot_colour = tbl[2*idx +: 2];
  endfunction : slot_colour

  logic adv_rise;
  logic ilk_low;
  logic ilk_mode;
  logic forced_off;

  // interlock and advance decode
  always_comb
  begin
    adv_rise   = st_reg.adv_sync[1] && !st_reg.adv_prev;
    ilk_mode   = GPIO07_INTERLOCK_MODE && !GPIO07_SAMPLE_MODE;
    ilk_low    = ilk_mode && !st_reg.ilk_sync[1];
    forced_off = ilk_mode && !st_reg.ilk_ok;
  end

  // next-state logic for the whole block except the sensor pin registers
  always_comb
  begin
    st_next           = st_reg;
    st_next.por_sync  = {st_reg.por_sync[0], POWER_ON_RESET_N};
    st_next.adv_sync  = {st_reg.adv_sync[0], PATTERN_ADVANCE_IN};
    st_next.ilk_sync  = {st_reg.ilk_sync[0], GPIO07_IN};
    st_next.cmp_sync  = {st_reg.cmp_sync[0], COMPARATOR_RESULT_IN};
    st_next.key_sync1 = GPIO_KEY_IN;
    st_next.key_sync2 = st_reg.key_sync1;
    st_next.adv_prev  = st_reg.adv_sync[1];
    st_next.ilk_prev  = st_reg.ilk_sync[1];
    st_next.adc_done  = 1'b0;
    // interlock release timer, restarts on every low level
    if (!ilk_mode)
    begin
      st_next.ilk_ok  = 1'b1;
      st_next.ilk_cnt = '0;
    end
    else if (ilk_low)
    begin
      st_next.ilk_ok  = 1'b0;
      st_next.ilk_cnt = '0;
    end
    else if (!st_reg.ilk_ok)
    begin
      if (st_reg.ilk_cnt >= 23'(RELEASE_COUNT - 1))
        st_next.ilk_ok = 1'b1;
      else
        st_next.ilk_cnt = st_reg.ilk_cnt + 23'h1;
    end
    // keypad inputs sampled only in keypad mode
    st_next.keys = KEYPAD_ENABLE ? st_reg.key_sync2 : 3'h0;
    // pwm reference and successive approximation
    st_next.pwm_cnt = st_reg.pwm_cnt + 8'h1;
    st_next.pwm_out = SENSOR_ENABLE && (st_reg.pwm_cnt < st_reg.sar_trial);
    if (!SENSOR_ENABLE)
    begin
      st_next.adc_run   = 1'b0;
      st_next.sar_trial = '0;
    end
    else if (!st_reg.adc_run)
    begin
      // restart the reference period so the first trial sees a whole pulse
      st_next.pwm_cnt   = '0;
      st_next.adc_run   = 1'b1;
      st_next.sar_mask  = 8'h80;
      st_next.sar_trial = 8'h80;
    end
    else if (st_reg.pwm_cnt == 8'hff)
    begin
      // comparator high means sensor at or above the reference: keep the bit
      logic [ADC_W-1:0] keep;
      keep = st_reg.cmp_sync[1] ? st_reg.sar_trial : (st_reg.sar_trial & ~st_reg.sar_mask);
      if (st_reg.sar_mask == 8'h01)
      begin
        st_next.adc_result = keep;
        st_next.adc_done   = 1'b1;
        st_next.adc_run    = 1'b0;
      end
      else
      begin
        st_next.sar_mask  = st_reg.sar_mask >> 1;
        st_next.sar_trial = keep | (st_reg.sar_mask >> 1);
      end
    end
    // pattern sequencer
    case (st_reg.state)
      ITSIO_INIT:
      begin
        st_next.colour = COLOUR_NONE;
        if (st_reg.por_sync[1])
        begin
          if (st_reg.init_cnt == 8'(INIT_CYC - 1))
          begin
            st_next.state     = ITSIO_IDLE;
            st_next.init_done = 1'b1;
          end
          else
            st_next.init_cnt = st_reg.init_cnt + 8'h1;
        end
      end
      ITSIO_IDLE:
      begin
        st_next.colour     = COLOUR_NONE;
        st_next.expose_out = 1'b0;
        if (adv_rise)
        begin
          st_next.state      = ITSIO_EXPOSE;
          st_next.exp_cnt    = '0;
          st_next.expose_out = 1'b1;
          st_next.first_out  = (st_reg.pat_idx == '0);
          st_next.colour     = slot_colour(SEQ_COLOURS, st_reg.pat_idx);
        end
      end
      ITSIO_EXPOSE:
      begin
        st_next.colour = slot_colour(SEQ_COLOURS, st_reg.pat_idx);
        if (st_reg.exp_cnt >= EXPOSE_CYCLES)
        begin
          st_next.state      = ITSIO_IDLE;
          st_next.expose_out = 1'b0;
          st_next.first_out  = 1'b0;
          st_next.colour     = COLOUR_NONE;
          st_next.pat_idx    = (st_reg.pat_idx >= SEQ_LENGTH) ? '0 : st_reg.pat_idx + 1'b1;
        end
        else
          st_next.exp_cnt = st_reg.exp_cnt + 16'h1;
      end
      default:
        st_next.state = ITSIO_INIT;
    endcase
    // interlock forces colour code and driver off, otherwise sequence controls them
    if (forced_off || ilk_low)
      st_next.colour = SEL_FORCED[1:0];
    st_next.drv_on = !(forced_off || ilk_low) && (st_next.colour != COLOUR_NONE);
    // pin-level reset restarts initialisation
    if (!st_reg.por_sync[1])
    begin
      st_next.state      = ITSIO_INIT;
      st_next.init_cnt   = '0;
      st_next.init_done  = 1'b0;
      st_next.colour     = COLOUR_NONE;
      st_next.drv_on     = 1'b0;
      st_next.expose_out = 1'b0;
      st_next.first_out  = 1'b0;
      st_next.pat_idx    = '0;
    end
  end

  // state register
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // sensor pin functions: unused pins drive zero as outputs
  itsio_sensor_s sens_q;
  logic          ilk_pin_q;
  logic          sh_q;
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sens_q    <= '0;
      ilk_pin_q <= 1'b0;
      sh_q      <= 1'b0;
    end
    else
    begin
      sens_q.ls_power    <= SENSOR_ENABLE;
      sens_q.ramp_charge <= SENSOR_ENABLE && st_reg.pwm_out;
      sens_q.calib       <= SENSOR_ENABLE && !st_reg.adc_run;
      sens_q.therm_power <= THERM_ENABLE;
      sens_q.sample_hold <= GPIO07_SAMPLE_MODE && st_reg.adc_run;
      ilk_pin_q          <= GPIO07_INTERLOCK_MODE && !GPIO07_SAMPLE_MODE;
      sh_q               <= GPIO07_SAMPLE_MODE;
    end
  end

  // output assignments, from flip-flops or constants, except KEY_PINS_OE, which follows KEYPAD_ENABLE directly
  assign ILLUM_COLOUR_CODE      = st_reg.colour;
  assign ILLUM_DRIVER_ON        = st_reg.drv_on;
  assign EXPOSURE_ACTIVE_OUT    = st_reg.expose_out;
  assign SEQUENCE_FIRST_OUT     = st_reg.first_out;
  assign COMPARATOR_REF_PWM_OUT = st_reg.pwm_out;
  assign ADC_RESULT             = st_reg.adc_result;
  assign ADC_DONE               = st_reg.adc_done;
  assign INIT_DONE              = st_reg.init_done;
  assign KEYPAD_STATE           = st_reg.keys;
  assign SENSOR_PINS_DOUT       = {sens_q.ls_power, sens_q.ramp_charge, sens_q.calib, sens_q.therm_power, 1'b0};
  assign SENSOR_PINS_OE         = 5'h1f;
  assign KEY_PINS_DOUT          = 3'h0;
  assign KEY_PINS_OE            = {3{!st_reg.keys[0] && 1'b0}} | {3{~KEYPAD_ENABLE}};
  assign GPIO07_DOUT            = sens_q.sample_hold;
  assign GPIO07_OE              = !ilk_pin_q;

  // checks
  a_reset_colour_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !st_reg.por_sync[1] |=> ILLUM_COLOUR_CODE == COLOUR_NONE) else $error("colour not low in reset");
  a_init_colour_low: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !INIT_DONE |-> ILLUM_COLOUR_CODE == COLOUR_NONE) else $error("colour before init done");
  a_interlock_forces: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ilk_low |=> !ILLUM_DRIVER_ON && ILLUM_COLOUR_CODE == 2'h0) else $error("interlock not forcing off");
  a_release_waits: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(st_reg.ilk_sync[1]) && ilk_mode |=> !st_reg.ilk_ok) else $error("interlock released early");
  a_restart_delay: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ilk_low |=> st_reg.ilk_cnt == '0) else $error("release timer not restarted");
  a_advance_exposes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    adv_rise && st_reg.state == ITSIO_IDLE && st_reg.por_sync[1] |=> EXPOSURE_ACTIVE_OUT) else $error("no exposure");
  a_expose_state: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    EXPOSURE_ACTIVE_OUT |-> st_reg.state == ITSIO_EXPOSE) else $error("exposure flag outside exposure");
  a_first_marks: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    SEQUENCE_FIRST_OUT |-> EXPOSURE_ACTIVE_OUT && st_reg.pat_idx == '0) else $error("first flag wrong");
  a_colour_sequence: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    st_reg.state == ITSIO_EXPOSE && !forced_off && !ilk_low && st_reg.por_sync[1] && st_reg.exp_cnt < EXPOSE_CYCLES
    |=> ILLUM_COLOUR_CODE == slot_colour(SEQ_COLOURS, $past(st_reg.pat_idx))) else $error("colour off sequence");
  c_exposure: cover property (@(posedge REF_CLK) disable iff (SYS_RST) $rose(EXPOSURE_ACTIVE_OUT));
  c_first: cover property (@(posedge REF_CLK) disable iff (SYS_RST) $rose(SEQUENCE_FIRST_OUT));
  c_release: cover property (@(posedge REF_CLK) disable iff (SYS_RST) ilk_mode && $rose(st_reg.ilk_ok));
  c_adc_done: cover property (@(posedge REF_CLK) disable iff (SYS_RST) ADC_DONE);
endmodule : itsio_top
`default_nettype wire

// ### rtl/itsio_pkg.sv
// Purpose: constants and carriers for the illumination, trigger and sensor pin block
// Assumes: 40 MHz reference clock
// Notes: shared by the single design module
package itsio_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned RELEASE_MS      = 100;
  localparam int unsigned RELEASE_CYC     = CLK_HZ / 1000 * RELEASE_MS;
  localparam int unsigned INIT_CYC        = 64;
  localparam int unsigned PWM_W           = 8;
  localparam int unsigned ADC_W           = 8;
  localparam int unsigned SEQ_MAX         = 16;
  localparam logic [1:0]  COLOUR_NONE     = 2'h0;
  localparam logic [1:0]  COLOUR_RED      = 2'h1;
  localparam logic [1:0]  COLOUR_GREEN    = 2'h2;
  localparam logic [1:0]  COLOUR_BLUE     = 2'h3;
  localparam logic [2:0]  SEL_FORCED      = 3'h0;

  typedef enum logic [1:0] {ITSIO_INIT, ITSIO_IDLE, ITSIO_EXPOSE} itsio_state_e;
  typedef enum logic [1:0] {ITSIO_PIN_GPIO, ITSIO_PIN_ALT, ITSIO_PIN_ALT2} itsio_pinmode_e;

  // one gpio pin as two signals
  typedef struct packed {
    logic dout;
    logic oe;
  } itsio_pin_s;

  // sensor pin functions driven out
  typedef struct packed {
    logic ls_power;
    logic ramp_charge;
    logic calib;
    logic therm_power;
    logic sample_hold;
  } itsio_sensor_s;
endpackage : itsio_pkg

// ### verif/itsio_cmp_model.sv
// Purpose: far-side comparator of the light-sensor converter
// Assumes: reference duty equals the high-cycle count of each pwm pulse
// Notes: behavioural; output pulled low while the converter is unused
`timescale 1ns/10ps
`default_nettype none
module itsio_cmp_model
  import itsio_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             enable,
  input  wire logic             pwm_in,
  input  wire logic [ADC_W-1:0] level,
  output logic                  result_out
);
  int unsigned run_len = 0;
  int unsigned width   = 0;

  // measure each high pulse of the reference to know its duty
  always @(posedge clk)
  begin
    if (pwm_in)
      run_len <= run_len + 1;
    else
    begin
      if (run_len != 0)
        width <= run_len;
      run_len <= 0;
    end
  end

  // high while the reference sits at or below the sensor level
  assign result_out = enable ? (width <= level) : 1'b0;
endmodule : itsio_cmp_model
`default_nettype wire

// ### verif/itsio_top_tb.sv
// Purpose: self-checking bench for the illumination, trigger and sensor pin block
// Assumes: 40 MHz clock, short interlock release count
// Notes: exposures and conversions are noted in queues and checked by watchers
`timescale 1ns/10ps
`default_nettype none
module itsio_top_tb;
  import itsio_pkg::*;
  localparam int unsigned REL = 20;
  typedef struct packed {logic [1:0] colour; logic first; logic drv; logic [16:0] len;} itsio_note_s;
  logic        ref_clk, sys_rst, por_n, adv, cmp_res, il_mode, sh_mode, sens_en, therm_en, key_en;
  logic        g7_in, drv_on, expo, first, pwm, adc_done, init_done, g7_dout, g7_oe;
  logic [1:0]  colour;
  logic [2:0]  key_in, keys, key_dout, key_oe;
  logic [3:0]  seq_len;
  logic [4:0]  sens_dout, sens_oe;
  logic [7:0]  level, adc_res;
  logic [15:0] expose;
  logic [31:0] seq_col;
  int          bad_count, checked, slot, n;
  itsio_note_s exp_q[$];
  logic [7:0]  adc_q[$];

  itsio_top #(.RELEASE_COUNT(REL)) uut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .POWER_ON_RESET_N(por_n), .PATTERN_ADVANCE_IN(adv),
    .COMPARATOR_RESULT_IN(cmp_res), .SEQ_LENGTH(seq_len), .SEQ_COLOURS(seq_col), .EXPOSE_CYCLES(expose),
    .GPIO07_INTERLOCK_MODE(il_mode), .GPIO07_SAMPLE_MODE(sh_mode), .SENSOR_ENABLE(sens_en),
    .THERM_ENABLE(therm_en), .KEYPAD_ENABLE(key_en), .GPIO_KEY_IN(key_in), .GPIO07_IN(g7_in),
    .ILLUM_COLOUR_CODE(colour), .ILLUM_DRIVER_ON(drv_on), .EXPOSURE_ACTIVE_OUT(expo),
    .SEQUENCE_FIRST_OUT(first), .COMPARATOR_REF_PWM_OUT(pwm), .ADC_RESULT(adc_res), .ADC_DONE(adc_done),
    .INIT_DONE(init_done), .KEYPAD_STATE(keys), .SENSOR_PINS_DOUT(sens_dout), .SENSOR_PINS_OE(sens_oe),
    .KEY_PINS_DOUT(key_dout), .KEY_PINS_OE(key_oe), .GPIO07_DOUT(g7_dout), .GPIO07_OE(g7_oe));

  itsio_cmp_model partner (.clk(ref_clk), .enable(sens_en), .pwm_in(pwm), .level(level), .result_out(cmp_res));

  // reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic cmp_val(input logic [23:0] got, input logic [23:0] want, input string what);
    checked++;
    if (got !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, want);
    end
  endtask : cmp_val

  task automatic cmp_note(input itsio_note_s got, input itsio_note_s want);
    cmp_val(24'(got), 24'(want), "exposure");
  endtask : cmp_note

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // step k edges and land just after the last one
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic pulse(input int k);
    adv = 1'b1;
    tick(k);
    adv = 1'b0;
    tick(1);
  endtask : pulse

  // note the expected exposure, then trigger it; extra adds a pulse that must be ignored
  task automatic advance(input logic forced, input logic extra);
    itsio_note_s w;
    w.colour = forced ? 2'h0 : seq_col[2*slot +: 2];
    w.first  = (slot == 0);
    w.drv    = (w.colour != 2'h0);
    w.len    = 17'(expose) + 17'd1;
    exp_q.push_back(w);
    slot = (slot == int'(seq_len)) ? 0 : slot + 1;
    pulse(3);
    if (extra)
      pulse(2);
    tick(int'(expose) + 12);
  endtask : advance

  // exposure watcher: each exposure takes the oldest note and is measured
  initial
  begin : watch
    itsio_note_s got;
    forever
    begin
      @(posedge ref_clk);
      if (expo === 1'b1)
      begin
        got = {colour, first, drv_on, 17'd0};
        while (expo === 1'b1 && got.len < 17'd1000)
        begin
          got.len++;
          @(posedge ref_clk);
        end
        if (exp_q.size() == 0)
          cmp_val(24'h1, 24'h0, "unexpected exposure");
        else
          cmp_note(got, exp_q.pop_front());
      end
    end
  end

  // conversion watcher
  always @(posedge ref_clk)
  begin
    if (adc_done === 1'b1)
    begin
      if (adc_q.size() == 0)
        cmp_val(24'h1, 24'h0, "extra conversion");
      else
        cmp_val(24'(adc_res), 24'(adc_q.pop_front()), "conversion");
    end
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial
  begin
    void'($urandom(75));
    {sys_rst, por_n, adv, il_mode, sh_mode, sens_en, therm_en, key_en, g7_in} = 9'b1_0000_0000;
    key_in = 3'h0;
    level = 8'h00;
    seq_len = 4'h3;
    slot = 0;
    expose = 16'(6 + $urandom % 10);
    seq_col = $urandom;
    seq_col[7:0] = 8'he4;
    tick(10);
    sys_rst = 1'b0;
    tick(5);
    cmp_val(24'({colour, init_done}), 24'h0, "colour in reset");
    por_n = 1'b1;
    pulse(3);
    n = 0;
    while (init_done !== 1'b1 && n < 200)
    begin
      cmp_val(24'({colour, drv_on}), 24'h0, "colour in init");
      n++;
      tick(1);
    end
    cmp_val(24'(n + 4 >= INIT_CYC), 24'h1, "init length");
    advance(1'b0, 1'b1);
    repeat (4) advance(1'b0, 1'b0);
    key_in = 3'($urandom);
    key_en = 1'b1;
    therm_en = 1'b1;
    tick(4);
    cmp_val(24'(keys), 24'(key_in), "keypad");
    cmp_val(24'({key_oe, key_dout}), 24'h0, "key pins");
    cmp_val(24'({sens_oe, sens_dout[1]}), 24'h3f, "sensor pins");
    key_en = 1'b0;
    sh_mode = 1'b1;
    tick(4);
    cmp_val(24'({keys, key_oe, key_dout, g7_oe}), 24'h71, "idle pins");
    sh_mode = 1'b0;
    il_mode = 1'b1;
    tick(4);
    cmp_val(24'(g7_oe), 24'h0, "interlock pin");
    advance(1'b1, 1'b0);
    g7_in = 1'b1;
    tick(REL - 1);
    g7_in = 1'b0;
    tick(3);
    g7_in = 1'b1;
    advance(1'b1, 1'b0);
    tick(REL + 10);
    advance(1'b0, 1'b0);
    il_mode = 1'b0;
    level = 8'($urandom % 128);
    adc_q.push_back(level);
    sens_en = 1'b1;
    n = 0;
    while (pwm !== 1'b1 && n < 300)
    begin
      n++;
      tick(1);
    end
    n = 0;
    while (pwm === 1'b1 && n < 300)
    begin
      n++;
      tick(1);
    end
    cmp_val(24'(n), 24'd128, "first trial duty");
    cmp_val(24'(sens_dout[4]), 24'h1, "sensor power");
    n = 0;
    while (adc_done !== 1'b1 && n < 2600)
    begin
      n++;
      tick(1);
    end
    tick(2);
    sens_en = 1'b0;
    cmp_val(24'(adc_q.size()), 24'h0, "conversion done");
    por_n = 1'b0;
    tick(4);
    cmp_val(24'({colour, init_done}), 24'h0, "second reset");
    end_sim();
  end
endmodule : itsio_top_tb
`default_nettype wire
